// >>> design/lpsc_device.sv
`timescale 1ns/10ps
// Operation
// [RQ1] halt instruction enters instruction idle state
// [RQ2] idle wakes to normal on pin events
// [RQ3] reset in idle initialises immediately
// [RQ4] stop request in idle returns to idle
// [RQ5] idle keeps servicing snoops and interrupts
// [RQ6] grant entered 20 clocks after acknowledge response
// [RQ7] bus reinit latched, not serviced, in grant
// [RQ8] reset in grant initialises, stays in grant
// [RQ9] stop released one clock after sleep release
// [RQ10] snoop or interrupt enters snoop state, returns
// [RQ11] grant events latched, serviced once at normal
// [RQ12] pending break shows any latched interrupt
// [RQ13] sleep entered only from grant on request
// [RQ14] host requests sleep only in grant
// [RQ15] sleep stops clocks, keeps context and loop
// [RQ16] host quiet during sleep and its edges
// [RQ17] reset in sleep resets directly to normal
// [RQ18] sleep held one clock, released before events
// [RQ19] grant keeps snooping and latching bus interrupts
// [RQ20] management handler may resume idle or normal
// [RQ21] sleep ignores snoops and interrupt signals
// [RQ22] registered state on bus clock, reset normal
// [RQ23] one acknowledge cycle before grant countdown
module lpsc_device (
   input wire logic clk,
   input wire logic reset,
   lpsc_if.dev link,
   input wire logic halt_exec,
   input wire logic mgmt_resume_idle,
   input wire logic irq_enable_flag,
   output logic [2:0] power_state,
   output logic core_clock_run,
   output logic snoop_logic_run,
   output logic pll_run,
   output logic init_core,
   output logic [5:0] wake_events,
   output logic deliverable_irq
);

   // ****************************************************************
   // state
   // ****************************************************************
   typedef struct packed {
      lpsc_pkg::lpsc_state_t state;
      lpsc_pkg::lpsc_state_t origin;
      lpsc_pkg::lpsc_ack_t ack;
      logic [lpsc_pkg::CNT_W-1:0] cnt;
      logic snoop_wait;
      logic from_grant;
      logic bus_request;
      logic stop_grant_cycle;
      logic break_n;
      logic core_clock_run;
      logic snoop_logic_run;
      logic pll_run;
      logic init_core;
      logic [lpsc_pkg::EV_COUNT-1:0] wake_events;
      logic deliverable_irq;
   } lpsc_dev_t;

   lpsc_dev_t cur;
   lpsc_dev_t next_cur;
   logic [lpsc_pkg::EV_COUNT-1:0] ev_live;
   logic [lpsc_pkg::EV_COUNT-1:0] ev_set;
   logic [lpsc_pkg::EV_COUNT-1:0] ev_clear;
   logic [lpsc_pkg::EV_COUNT-1:0] pend;
   logic stop_req;
   logic sleep_req;
   logic cpu_rst;
   logic bus_txn;

   // ****************************************************************
   // input decode
   // ****************************************************************
   assign stop_req = ~link.clock_stop_request_n;
   assign sleep_req = ~link.sleep_request_n;
   assign cpu_rst = ~link.cpu_reset_n;
   assign bus_txn = link.snoop_start | link.irq_message;

   always_comb begin
      ev_live = lpsc_pkg::EV_NONE;
      ev_live[lpsc_pkg::EV_MGMT] = ~link.system_mgmt_irq_n;
      ev_live[lpsc_pkg::EV_INIT] = ~link.restart_n;
      ev_live[lpsc_pkg::EV_REINIT] = ~link.bus_reinitialise_n;
      ev_live[lpsc_pkg::EV_LOCAL0] = link.local_irq_pins[0];
      ev_live[lpsc_pkg::EV_LOCAL1] = link.local_irq_pins[1];
      ev_live[lpsc_pkg::EV_MSG] = link.irq_message;
   end

   lpsc_event_latch #(
      .W(lpsc_pkg::EV_COUNT)
   ) lpsc_event_latch_i (
      .clk(clk),
      .reset(reset),
      .set(ev_set),
      .clear(ev_clear),
      .pend(pend)
   );

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      next_cur = cur;
      next_cur.stop_grant_cycle = 1'b0;
      next_cur.init_core = 1'b0;
      next_cur.wake_events = lpsc_pkg::EV_NONE;
      ev_set = lpsc_pkg::EV_NONE;
      ev_clear = lpsc_pkg::EV_NONE;

      if (cpu_rst) begin
         next_cur.init_core = 1'b1;
         ev_clear = lpsc_pkg::EV_ALL;
         next_cur.ack = lpsc_pkg::LPSC_ACK_NONE;
         next_cur.bus_request = 1'b0;
         next_cur.snoop_wait = 1'b0;
         if (cur.state == lpsc_pkg::LPSC_GRANT) begin
            next_cur.state = lpsc_pkg::LPSC_GRANT; // RQ8
         end else begin
            next_cur.state = lpsc_pkg::LPSC_NORMAL; // RQ3 RQ17
            next_cur.origin = lpsc_pkg::LPSC_NORMAL;
         end
      end else if (cur.ack != lpsc_pkg::LPSC_ACK_NONE) begin
         case (cur.ack)
            lpsc_pkg::LPSC_ACK_REQ: begin
               if (link.bus_grant) begin
                  next_cur.bus_request = 1'b0;
                  next_cur.stop_grant_cycle = 1'b1; // RQ23
                  next_cur.ack = lpsc_pkg::LPSC_ACK_RESP;
               end
            end
            lpsc_pkg::LPSC_ACK_RESP: begin
               if (link.response_phase) begin
                  next_cur.cnt = lpsc_pkg::GRANT_DELAY_CNT; // RQ6
                  next_cur.ack = lpsc_pkg::LPSC_ACK_COUNT;
               end
            end
            default: begin
               if (cur.cnt == lpsc_pkg::CNT_ZERO) begin
                  next_cur.state = lpsc_pkg::LPSC_GRANT; // RQ6
                  next_cur.ack = lpsc_pkg::LPSC_ACK_NONE;
               end else begin
                  next_cur.cnt = cur.cnt - 5'h01;
               end
            end
         endcase
      end else begin
         case (cur.state)
            lpsc_pkg::LPSC_NORMAL: begin
               if (stop_req) begin
                  next_cur.origin = lpsc_pkg::LPSC_NORMAL;
                  next_cur.bus_request = 1'b1; // RQ23
                  next_cur.ack = lpsc_pkg::LPSC_ACK_REQ;
               end else if (halt_exec | mgmt_resume_idle) begin
                  next_cur.state = lpsc_pkg::LPSC_IDLE; // RQ1 RQ20
               end
            end
            lpsc_pkg::LPSC_IDLE: begin
               if (stop_req) begin
                  next_cur.origin = lpsc_pkg::LPSC_IDLE; // RQ4
                  next_cur.bus_request = 1'b1; // RQ23
                  next_cur.ack = lpsc_pkg::LPSC_ACK_REQ;
               end else if ((|ev_live[4:0]) | (|pend)) begin
                  next_cur.state = lpsc_pkg::LPSC_NORMAL; // RQ2
                  next_cur.wake_events = ev_live | pend; // RQ11
                  ev_clear = lpsc_pkg::EV_ALL;
               end else if (bus_txn) begin
                  next_cur.state = lpsc_pkg::LPSC_SNOOP; // RQ5 RQ10
                  next_cur.from_grant = 1'b0;
                  next_cur.snoop_wait = link.snoop_start;
                  ev_set[lpsc_pkg::EV_MSG] = link.irq_message;
               end
            end
            lpsc_pkg::LPSC_SNOOP: begin
               if (cur.from_grant) begin
                  ev_set = ev_live; // RQ7 RQ11
               end else begin
                  ev_set[lpsc_pkg::EV_MSG] = link.irq_message;
               end
               // return state kept apart from the stop origin
               if (!cur.snoop_wait || link.snoop_done) begin
                  next_cur.state = cur.from_grant ?
                     lpsc_pkg::LPSC_GRANT : lpsc_pkg::LPSC_IDLE; // RQ10
                  next_cur.snoop_wait = 1'b0;
               end
            end
            lpsc_pkg::LPSC_GRANT: begin
               ev_set = ev_live; // RQ7 RQ11 RQ19
               if (sleep_req) begin
                  next_cur.state = lpsc_pkg::LPSC_SLEEP; // RQ13
               end else if (!stop_req) begin
                  next_cur.state = cur.origin; // RQ4 RQ8
                  if (cur.origin == lpsc_pkg::LPSC_NORMAL) begin
                     next_cur.wake_events = pend; // RQ11
                     ev_clear = lpsc_pkg::EV_ALL;
                  end
               end else if (bus_txn) begin
                  next_cur.state = lpsc_pkg::LPSC_SNOOP; // RQ10 RQ19
                  next_cur.from_grant = 1'b1;
                  next_cur.snoop_wait = link.snoop_start;
               end
            end
            lpsc_pkg::LPSC_SLEEP: begin
               // no latching, no snoops while asleep
               if (!sleep_req) begin
                  next_cur.state = lpsc_pkg::LPSC_GRANT; // RQ21
               end
            end
            default: begin
               next_cur.state = lpsc_pkg::LPSC_NORMAL;
            end
         endcase
      end

      // clock gating follows the coming state
      next_cur.core_clock_run =
         (next_cur.state == lpsc_pkg::LPSC_NORMAL);
      next_cur.snoop_logic_run =
         (next_cur.state != lpsc_pkg::LPSC_SLEEP); // RQ15
      next_cur.pll_run = 1'b1; // RQ15
      next_cur.break_n = ~((next_cur.state == lpsc_pkg::LPSC_GRANT ||
         (next_cur.state == lpsc_pkg::LPSC_SNOOP && next_cur.from_grant)) &&
         (|((pend & ~ev_clear) | ev_set))); // RQ12
      next_cur.deliverable_irq = irq_enable_flag &
         (|(pend & lpsc_pkg::EV_IRQ_MASK));
   end

   // ****************************************************************
   // registers
   // ****************************************************************
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cur <= '0; // RQ22
         cur.state <= lpsc_pkg::LPSC_NORMAL;
         cur.origin <= lpsc_pkg::LPSC_NORMAL;
         cur.ack <= lpsc_pkg::LPSC_ACK_NONE;
         cur.break_n <= 1'b1;
         cur.core_clock_run <= 1'b1;
         cur.snoop_logic_run <= 1'b1;
         cur.pll_run <= 1'b1;
      end else begin
         cur <= next_cur;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign link.bus_request = cur.bus_request;
   assign link.stop_grant_cycle = cur.stop_grant_cycle;
   assign link.pending_break_event_n = cur.break_n;
   assign power_state = cur.state;
   assign core_clock_run = cur.core_clock_run;
   assign snoop_logic_run = cur.snoop_logic_run;
   assign pll_run = cur.pll_run;
   assign init_core = cur.init_core;
   assign wake_events = cur.wake_events;
   assign deliverable_irq = cur.deliverable_irq;
endmodule

// >>> pkg/lpsc_pkg.sv
package lpsc_pkg;

   // ****************************************************************
   // power states, gray coded along normal-idle-snoop-grant-sleep
   // ****************************************************************
   typedef enum logic [2:0] {
      LPSC_NORMAL = 3'h0,
      LPSC_IDLE   = 3'h1,
      LPSC_SNOOP  = 3'h3,
      LPSC_GRANT  = 3'h2,
      LPSC_SLEEP  = 3'h6
   } lpsc_state_t;

   // stop-grant acknowledge sequence phases
   typedef enum logic [1:0] {
      LPSC_ACK_NONE  = 2'h0,
      LPSC_ACK_REQ   = 2'h1,
      LPSC_ACK_RESP  = 2'h3,
      LPSC_ACK_COUNT = 2'h2
   } lpsc_ack_t;

   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int GRANT_DELAY_CLK = 20;
   localparam int CNT_W = 5;
   localparam logic [CNT_W-1:0] GRANT_DELAY_CNT =
      CNT_W'(GRANT_DELAY_CLK - 1);
   localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;

   // ****************************************************************
   // latched event vector layout
   // ****************************************************************
   localparam int EV_MGMT = 0;
   localparam int EV_INIT = 1;
   localparam int EV_REINIT = 2;
   localparam int EV_LOCAL0 = 3;
   localparam int EV_LOCAL1 = 4;
   localparam int EV_MSG = 5;
   localparam int EV_COUNT = 6;
   localparam logic [EV_COUNT-1:0] EV_NONE = 6'h00;
   localparam logic [EV_COUNT-1:0] EV_ALL = 6'h3f;
   localparam logic [EV_COUNT-1:0] EV_IRQ_MASK = 6'h38;

endpackage

// >>> pkg/lpsc_if.sv
`timescale 1ns/10ps
interface lpsc_if (
   input wire logic clk
);
   logic clock_stop_request_n;
   logic sleep_request_n;
   logic cpu_reset_n;
   logic system_mgmt_irq_n;
   logic restart_n;
   logic bus_reinitialise_n;
   logic [1:0] local_irq_pins;
   logic snoop_start;
   logic snoop_done;
   logic irq_message;
   logic bus_grant;
   logic response_phase;
   logic bus_request;
   logic stop_grant_cycle;
   logic pending_break_event_n;

   modport dev (
      input clock_stop_request_n, sleep_request_n, cpu_reset_n,
      input system_mgmt_irq_n, restart_n, bus_reinitialise_n,
      input local_irq_pins, snoop_start, snoop_done, irq_message,
      input bus_grant, response_phase,
      output bus_request, stop_grant_cycle, pending_break_event_n
   );

   modport host (
      output clock_stop_request_n, sleep_request_n, cpu_reset_n,
      output system_mgmt_irq_n, restart_n, bus_reinitialise_n,
      output local_irq_pins, snoop_start, snoop_done, irq_message,
      output bus_grant, response_phase,
      input bus_request, stop_grant_cycle, pending_break_event_n
   );
endinterface

// >>> design/lpsc_event_latch.sv
`timescale 1ns/10ps
// sticky event bits; a set in the clearing cycle survives
module lpsc_event_latch #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [W-1:0] set,
   input wire logic [W-1:0] clear,
   output logic [W-1:0] pend
);
   typedef struct packed {
      logic [W-1:0] pend;
   } lpsc_latch_t;

   lpsc_latch_t cur;
   lpsc_latch_t next_cur;

   always_comb begin
      next_cur = cur;
      next_cur.pend = (cur.pend & ~clear) | set;
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   assign pend = cur.pend;
endmodule

// >>> design/lpsc_host.sv
`timescale 1ns/10ps
module lpsc_host (
   input wire logic clk,
   input wire logic reset,
   lpsc_if.host link,
   input wire logic want_stop,
   input wire logic want_sleep,
   input wire logic do_reset,
   input wire logic sys_mgmt,
   input wire logic sys_init,
   input wire logic sys_reinit,
   input wire logic [1:0] sys_local,
   input wire logic sys_snoop,
   input wire logic sys_irq_msg,
   output logic device_in_grant,
   output logic device_asleep,
   output logic wake_request
);
   typedef struct packed {
      logic stop_n;
      logic sleep_n;
      logic cpu_reset_n;
      logic mgmt_n;
      logic init_n;
      logic reinit_n;
      logic [1:0] lirq;
      logic snoop_start;
      logic snoop_done;
      logic irq_message;
      logic bus_grant;
      logic response_phase;
      logic counting;
      logic [lpsc_pkg::CNT_W-1:0] cnt;
      logic in_grant;
      logic wake_request;
   } lpsc_host_t;

   lpsc_host_t cur;
   lpsc_host_t next_cur;
   logic quiet;
   logic any_event;

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      next_cur = cur;
      next_cur.snoop_start = 1'b0;
      next_cur.irq_message = 1'b0;
      next_cur.bus_grant = 1'b0;
      next_cur.response_phase = 1'b0;
      next_cur.snoop_done = cur.snoop_start;
      any_event = sys_mgmt | sys_init | sys_reinit | (|sys_local) |
         sys_snoop | sys_irq_msg;

      // bus arbitration and response for the acknowledge cycle
      next_cur.bus_grant = link.bus_request & ~cur.bus_grant;
      next_cur.response_phase = link.stop_grant_cycle;
      if (cur.response_phase) begin
         next_cur.counting = 1'b1;
         next_cur.cnt = lpsc_pkg::GRANT_DELAY_CNT;
      end else if (cur.counting) begin
         if (cur.cnt == lpsc_pkg::CNT_ZERO) begin
            next_cur.counting = 1'b0;
            next_cur.in_grant = 1'b1;
         end else begin
            next_cur.cnt = cur.cnt - 5'h01;
         end
      end

      if (do_reset) begin
         next_cur.cpu_reset_n = 1'b0;
         next_cur.sleep_n = 1'b1; // RQ17
         next_cur.stop_n = 1'b1; // RQ17
         next_cur.in_grant = 1'b0;
         next_cur.counting = 1'b0;
      end else begin
         next_cur.cpu_reset_n = 1'b1;
         if (cur.sleep_n) begin
            if (want_sleep && cur.in_grant && !any_event &&
                !cur.snoop_start && !cur.snoop_done) begin
               next_cur.sleep_n = 1'b0; // RQ14
            end else if (!want_stop) begin
               next_cur.stop_n = 1'b1; // RQ9
               next_cur.in_grant = 1'b0;
            end else begin
               next_cur.stop_n = 1'b0;
            end
         end else if (!want_sleep || any_event) begin
            next_cur.sleep_n = 1'b1; // RQ18
         end
      end

      // pins and bus traffic held still around sleep
      quiet = ~cur.sleep_n | ~next_cur.sleep_n; // RQ16
      if (!quiet && !do_reset) begin
         next_cur.mgmt_n = ~sys_mgmt;
         next_cur.init_n = ~sys_init;
         next_cur.reinit_n = ~sys_reinit;
         next_cur.lirq = sys_local;
         next_cur.snoop_start = sys_snoop & ~cur.snoop_start;
         next_cur.irq_message = sys_irq_msg;
      end else if (do_reset) begin
         next_cur.mgmt_n = 1'b1;
         next_cur.init_n = 1'b1;
         next_cur.reinit_n = 1'b1;
         next_cur.lirq = 2'h0;
      end
      next_cur.wake_request = ~link.pending_break_event_n;
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cur <= '0;
         cur.stop_n <= 1'b1;
         cur.sleep_n <= 1'b1;
         cur.cpu_reset_n <= 1'b1;
         cur.mgmt_n <= 1'b1;
         cur.init_n <= 1'b1;
         cur.reinit_n <= 1'b1;
      end else begin
         cur <= next_cur;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign link.clock_stop_request_n = cur.stop_n;
   assign link.sleep_request_n = cur.sleep_n;
   assign link.cpu_reset_n = cur.cpu_reset_n;
   assign link.system_mgmt_irq_n = cur.mgmt_n;
   assign link.restart_n = cur.init_n;
   assign link.bus_reinitialise_n = cur.reinit_n;
   assign link.local_irq_pins = cur.lirq;
   assign link.snoop_start = cur.snoop_start;
   assign link.snoop_done = cur.snoop_done;
   assign link.irq_message = cur.irq_message;
   assign link.bus_grant = cur.bus_grant;
   assign link.response_phase = cur.response_phase;
   assign device_in_grant = cur.in_grant;
   assign device_asleep = ~cur.sleep_n;
   assign wake_request = cur.wake_request;
endmodule

// >>> tb/lpsc_monitor.sv
`timescale 1ns/10ps
module lpsc_monitor (
   input wire logic clk,
   input wire logic reset,
   input wire logic clock_stop_request_n,
   input wire logic sleep_request_n,
   input wire logic cpu_reset_n,
   input wire logic snoop_start,
   input wire logic snoop_done,
   input wire logic bus_grant,
   input wire logic response_phase,
   input wire logic bus_request,
   input wire logic stop_grant_cycle,
   input wire logic pending_break_event_n
);
   // ****************************************************************
   // entry countdown and handshake checks
   // ****************************************************************
   logic [4:0] cnt;

   default clocking dc @(posedge clk);
   endclocking
   default disable iff (reset);

   // counts the clocks between response and grant entry
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cnt <= 5'h00;
      end else if (response_phase) begin
         cnt <= 5'h14;
      end else if (cnt != 5'h00) begin
         cnt <= cnt - 5'h01;
      end
   end

   sequence ack_walk;
      ##1 bus_grant ##1 (stop_grant_cycle && !bus_request) ##1 response_phase;
   endsequence

   a_req_needs_stop: assert property (
      $rose(bus_request) |-> $past(!clock_stop_request_n))
      else $error("bus request without stop request");
   a_ack_order: assert property ($rose(bus_request) |-> ack_walk)
      else $error("acknowledge cycle out of order");
   a_single_ack: assert property (
      stop_grant_cycle |=> !stop_grant_cycle [*8])
      else $error("acknowledge cycle repeated");
   a_count_quiet: assert property (
      cnt != 5'h00 |-> pending_break_event_n && !bus_request)
      else $error("activity during entry countdown");
   a_break_in_grant: assert property (
      !pending_break_event_n |-> $past(!clock_stop_request_n))
      else $error("pending break outside grant");
   a_stop_after_wake: assert property (
      $rose(clock_stop_request_n) && cpu_reset_n |-> $past(sleep_request_n))
      else $error("stop released with sleep");
   a_sleep_in_stop: assert property (
      !sleep_request_n |-> !clock_stop_request_n)
      else $error("sleep requested outside grant");
   a_reset_frees: assert property (
      $fell(cpu_reset_n) |-> sleep_request_n && clock_stop_request_n)
      else $error("requests held across reset");
   a_sleep_quiet: assert property (
      !sleep_request_n |-> !snoop_start && !bus_grant)
      else $error("bus traffic during sleep");
   a_snoop_served: assert property (snoop_start |=> snoop_done)
      else $error("snoop not serviced");
endmodule

// >>> tb/low_power_state_controller_tb.sv
`timescale 1ns/10ps
module low_power_state_controller_tb;
   // ****************************************************************
   // stimulus, instances and result queues
   // ****************************************************************
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic halt_exec = 1'b0, mgmt_resume_idle = 1'b0, irq_enable_flag = 1'b0;
   logic want_stop = 1'b0, want_sleep = 1'b0, do_reset = 1'b0;
   logic sys_mgmt = 1'b0, sys_init = 1'b0, sys_reinit = 1'b0;
   logic sys_snoop = 1'b0, sys_irq_msg = 1'b0, init_seen = 1'b0;
   logic wake_req, asleep, in_grant;
   logic [1:0] sys_local = 2'h0;
   logic [5:0] exp_st;
   logic [2:0] power_state, prev = 3'h0;
   logic core_clock_run, snoop_logic_run, pll_run, init_core, deliverable_irq;
   logic [5:0] wake_events;
   logic [31:0] seed = 32'hed1a2e07;
   logic [2:0] st_q[$];
   logic [5:0] ev_q[$];
   int fail_count = 0;
   int num_checks = 0;
   int cyc = 0;
   int rp = 0;

   lpsc_if lk (.clk(clk));
   lpsc_device lpsc_device_i (.clk(clk), .reset(reset), .link(lk),
      .halt_exec(halt_exec), .mgmt_resume_idle(mgmt_resume_idle),
      .irq_enable_flag(irq_enable_flag), .power_state(power_state),
      .core_clock_run(core_clock_run), .snoop_logic_run(snoop_logic_run),
      .pll_run(pll_run), .init_core(init_core), .wake_events(wake_events),
      .deliverable_irq(deliverable_irq));
   lpsc_host lpsc_host_i (.clk(clk), .reset(reset), .link(lk),
      .want_stop(want_stop), .want_sleep(want_sleep), .do_reset(do_reset),
      .sys_mgmt(sys_mgmt), .sys_init(sys_init), .sys_reinit(sys_reinit),
      .sys_local(sys_local), .sys_snoop(sys_snoop), .sys_irq_msg(sys_irq_msg),
      .device_in_grant(in_grant), .device_asleep(asleep),
      .wake_request(wake_req));
   lpsc_monitor lpsc_monitor_i (.clk(clk), .reset(reset),
      .clock_stop_request_n(lk.clock_stop_request_n),
      .sleep_request_n(lk.sleep_request_n), .cpu_reset_n(lk.cpu_reset_n),
      .snoop_start(lk.snoop_start), .snoop_done(lk.snoop_done),
      .bus_grant(lk.bus_grant), .response_phase(lk.response_phase),
      .bus_request(lk.bus_request), .stop_grant_cycle(lk.stop_grant_cycle),
      .pending_break_event_n(lk.pending_break_event_n));

   initial begin
      forever #12.5 clk = ~clk;
   end

   function automatic logic [31:0] xs(input logic [31:0] v);
      v = v ^ (v << 13);
      v = v ^ (v >> 17);
      v = v ^ (v << 5);
      return v;
   endfunction

   task chk(input logic [5:0] got, input logic [5:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task results;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task step(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask

   // waits until every noted result has shown up
   task settle;
      int i;
      for (i = 0; i < 300 && st_q.size() + ev_q.size() > 0; i++) step(1);
      if (i == 300) begin
         fail_count++;
         $display("[FAIL] %0t expected result missing", $time);
      end
   endtask

   task to_grant;
      st_q.push_back(lpsc_pkg::LPSC_GRANT);
      want_stop = 1'b1;
      settle();
      step(2);
      chk({5'h00, in_grant}, 6'h01);
   endtask

   // ****************************************************************
   // output watcher
   // ****************************************************************
   always @(posedge clk) begin
      cyc++;
      if (lk.response_phase) rp = cyc;
      if (init_core === 1'b1) init_seen = 1'b1;
      if (!reset && power_state !== prev) begin
         exp_st = st_q.size() > 0 ? 6'(st_q.pop_front()) : 6'h3f;
         chk(6'(power_state), exp_st);
         if (power_state === lpsc_pkg::LPSC_GRANT && prev[1] === 1'b0)
            chk(6'(cyc - rp), 6'h15);
      end
      if (!reset && wake_events !== 6'h00 && ev_q.size() > 0)
         chk(wake_events, ev_q.pop_front());
      prev = power_state;
   end

   // ****************************************************************
   // scenarios
   // ****************************************************************
   initial begin
      step(8);
      reset = 1'b0;
      step(2);
      st_q.push_back(lpsc_pkg::LPSC_IDLE);
      halt_exec = 1'b1;
      step(1);
      halt_exec = 1'b0;
      settle();
      st_q.push_back(lpsc_pkg::LPSC_NORMAL);
      sys_local = 2'h1;
      settle();
      sys_local = 2'h0;
      step(2);
      st_q.push_back(lpsc_pkg::LPSC_IDLE);
      mgmt_resume_idle = 1'b1;
      step(1);
      mgmt_resume_idle = 1'b0;
      settle();
      st_q.push_back(lpsc_pkg::LPSC_NORMAL);
      do_reset = 1'b1;
      step(1);
      do_reset = 1'b0;
      settle();
      chk({5'h00, init_seen}, 6'h01);
      st_q.push_back(lpsc_pkg::LPSC_IDLE);
      halt_exec = 1'b1;
      step(1);
      halt_exec = 1'b0;
      settle();
      st_q.push_back(lpsc_pkg::LPSC_SNOOP);
      st_q.push_back(lpsc_pkg::LPSC_IDLE);
      sys_snoop = 1'b1;
      step(1);
      sys_snoop = 1'b0;
      settle();
      to_grant();
      st_q.push_back(lpsc_pkg::LPSC_IDLE);
      want_stop = 1'b0;
      settle();
      st_q.push_back(lpsc_pkg::LPSC_NORMAL);
      sys_mgmt = 1'b1;
      settle();
      sys_mgmt = 1'b0;
      step(2);
      // grant with random latched events, snoops and bus interrupts
      for (int k = 0; k < 4; k++) begin
         seed = xs(seed);
         irq_enable_flag = seed[5];
         to_grant();
         {sys_local, sys_reinit, sys_init, sys_mgmt} = seed[4:0];
         st_q.push_back(lpsc_pkg::LPSC_SNOOP);
         st_q.push_back(lpsc_pkg::LPSC_GRANT);
         st_q.push_back(lpsc_pkg::LPSC_SNOOP);
         st_q.push_back(lpsc_pkg::LPSC_GRANT);
         sys_irq_msg = 1'b1;
         step(1);
         sys_irq_msg = 1'b0;
         step(4);
         sys_snoop = 1'b1;
         step(1);
         sys_snoop = 1'b0;
         settle();
         {sys_local, sys_reinit, sys_init, sys_mgmt} = 5'h00;
         step(3);
         chk({5'h00, lk.pending_break_event_n}, 6'h00);
         chk({5'h00, wake_req}, 6'h01);
         chk({5'h00, deliverable_irq}, {5'h00, seed[5]});
         st_q.push_back(lpsc_pkg::LPSC_NORMAL);
         ev_q.push_back({1'b1, seed[4:0]});
         want_stop = 1'b0;
         settle();
         step(3);
      end
      to_grant();
      st_q.push_back(lpsc_pkg::LPSC_SLEEP);
      want_sleep = 1'b1;
      settle();
      step(2);
      chk({3'h0, core_clock_run, snoop_logic_run, pll_run}, 6'h01);
      chk({5'h00, asleep}, 6'h01);
      st_q.push_back(lpsc_pkg::LPSC_GRANT);
      want_sleep = 1'b0;
      settle();
      st_q.push_back(lpsc_pkg::LPSC_NORMAL);
      want_stop = 1'b0;
      settle();
      step(2);
      to_grant();
      st_q.push_back(lpsc_pkg::LPSC_SLEEP);
      want_sleep = 1'b1;
      settle();
      st_q.push_back(lpsc_pkg::LPSC_NORMAL);
      do_reset = 1'b1;
      want_sleep = 1'b0;
      want_stop = 1'b0;
      step(1);
      do_reset = 1'b0;
      settle();
      step(4);
      results();
   end

   initial begin
      repeat (5000) @(posedge clk);
      fail_count++;
      $display("[FAIL] %0t watchdog expired", $time);
      results();
   end
endmodule
